// ### dv/cdx_exec_sva.sv
// Checker for the execute block: op timing and results at its ports.
// Assumes clock enable stays high while an instruction is in flight.
`timescale 1ns/1ns
`default_nettype none
module cdx_exec_sva (
  input wire logic ref_clk_i, // Clock
  input wire logic reset_n_i, // Reset
  input wire logic ce_i, // Enable
  input wire logic instr_valid_i, // Offer
  input wire logic instr_ready_o, // Ready
  input wire logic [2:0] op_i, // Op
  input wire logic dest_i, // Dest
  input wire logic [10:0] literal_i, // Literal
  input wire logic [6:0] pc_upper_latch_i, // Latch
  input wire logic done_o, // Retired
  input wire logic [7:0] acc_o, // Acc
  input wire logic zero_o, // Zero
  input wire logic [14:0] pc_o, // Target
  input wire logic pc_load_o, // Load
  input wire logic skip_o, // Skip
  input wire logic file_wr_o, // Write
  input wire logic [7:0] file_wr_data_o // Data
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Op taken this edge, nop otherwise; result wherever it landed
  wire logic [2:0] tk = ce_i && instr_valid_i && instr_ready_o ? op_i : 3'h0;
  wire logic [7:0] res = file_wr_o ? file_wr_data_o : acc_o;
  a_clear_file: assert property (
    tk == 3'h1 |-> ##2 file_wr_o && file_wr_data_o == 8'h00 && zero_o) else $error("clear file");
  a_clear_acc: assert property (
    tk == 3'h2 |-> ##2 acc_o == 8'h00 && zero_o && !file_wr_o) else $error("clear acc");
  a_dest_route: assert property (
    tk inside {3'h3, 3'h4, 3'h5} |-> ##2 file_wr_o == $past(dest_i, 2)) else $error("dest");
  a_dec_zero: assert property (
    tk == 3'h3 |-> ##2 zero_o == (res == 8'h00) && !skip_o) else $error("decrement");
  a_skip_flags: assert property (
    tk inside {3'h4, 3'h5} |-> ##2 zero_o == $past(zero_o, 2) && skip_o == (res == 8'h00))
    else $error("skip op");
  a_skip_cycles: assert property (
    skip_o |-> !done_o ##1 done_o) else $error("skip length");
  a_jump_target: assert property (
    tk == 3'h6 |-> ##2 pc_load_o && pc_o == {$past(pc_upper_latch_i[6:3], 2),
    $past(literal_i, 2)} ##1 done_o) else $error("jump");
  a_or_literal: assert property (
    tk == 3'h7 |-> ##2 acc_o == ($past(acc_o, 2) | $past(literal_i[7:0], 2))
    && zero_o == (acc_o == 8'h00)) else $error("or literal");
  c_skip: cover property (skip_o);
  c_jump: cover property (pc_load_o);
  c_write: cover property (file_wr_o && done_o);
  c_stall: cover property (instr_valid_i && instr_ready_o && !ce_i);
endmodule // cdx_exec_sva
bind cdx_exec cdx_exec_sva cdx_exec_sva_inst (.*);
`default_nettype wire

// ### dv/cdx_fetch_model.sv
// Fetch stage model: offers one instruction per go pulse, holds it until taken.
// Assumes req_i is steady in the go cycle; its top field sets the offer delay.
`timescale 1ns/1ns
`default_nettype none
module cdx_fetch_model (
  input wire logic ref_clk_i, // Clock
  input wire logic reset_n_i, // Reset
  input wire logic go_i, // Load request
  input wire logic [30:0] req_i, // Delay and fields
  input wire logic ready_i, // Block ready
  output logic valid_o, // Offer
  output logic [28:0] cmd_o // Offered fields
);
  logic [1:0] cnt_r;
  // Fields flip after the take, so a late sampler picks up garbage
  always @(posedge ref_clk_i or negedge reset_n_i)
    if (!reset_n_i) {valid_o, cnt_r} <= 3'h0;
    else if (go_i) {valid_o, cnt_r, cmd_o} <= {req_i[30:29] == 2'h0, req_i};
    else if (valid_o && ready_i) {valid_o, cmd_o} <= {1'b0, ~cmd_o};
    else if (cnt_r != 2'h0) {valid_o, cnt_r} <= {cnt_r == 2'h1, cnt_r - 2'h1};
endmodule // cdx_fetch_model
`default_nettype wire

// ### dv/tb.sv
// Bench for the execute block: fetch model in front, integer model beside.
// Assumes the checker binds itself; clock enable drops only before a take.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 0, rst_n = 0, go = 0, pre_en = 0, vld, rdy, done, zero, pcl, skp, wr;
  logic s_wr = 0, s_skp = 0, s_pcl = 0, ce = 1;
  logic [6:0] pre_a = 0, wa;
  logic [7:0] pre_d = 0, acc, wd;
  logic [14:0] pc;
  logic [30:0] req = 0;
  logic [28:0] cmd;
  int n_mismatch = 0, num_checks = 0, seed = 9, w = 0, z = 0, s_busy = 0, mem[128];
  // Boundary cases: op, dest, address, literal, latch
  int tbl[16][5] = '{'{1, 0, 127, 0, 0}, '{2, 1, 0, 0, 0}, '{7, 0, 0, 11'h7a5, 0},
    '{2, 0, 0, 0, 0}, '{7, 0, 0, 11'h700, 0}, '{3, 1, 7, 0, 0}, '{3, 0, 7, 0, 0},
    '{4, 1, 5, 0, 0}, '{4, 0, 5, 0, 0}, '{4, 0, 8, 0, 0}, '{5, 1, 6, 0, 0},
    '{5, 0, 9, 0, 0}, '{5, 0, 127, 0, 0}, '{6, 0, 0, 2047, 7'h78},
    '{6, 0, 0, 0, 7'h07}, '{0, 0, 0, 0, 0}};
  cdx_fetch_model cdx_fetch_model_inst (.ref_clk_i(clk), .reset_n_i(rst_n), .go_i(go),
    .req_i(req), .ready_i(rdy && ce), .valid_o(vld), .cmd_o(cmd));
  // Fetch ready is gated by the enable, so it sees a take only while enabled
  cdx_exec cdx_exec_inst (.ref_clk_i(clk), .reset_n_i(rst_n), .ce_i(ce),
    .instr_valid_i(vld), .op_i(cmd[28:26]), .dest_i(cmd[25]), .file_addr_i(cmd[24:18]),
    .literal_i(cmd[17:7]), .pc_upper_latch_i(cmd[6:0]), .preload_en_i(pre_en),
    .preload_addr_i(pre_a), .preload_data_i(pre_d), .instr_ready_o(rdy), .done_o(done),
    .acc_o(acc), .zero_o(zero), .pc_o(pc), .pc_load_o(pcl), .skip_o(skp),
    .file_wr_o(wr), .file_wr_addr_o(wa), .file_wr_data_o(wd));
  // 10 MHz core clock
  initial forever #50 clk = ~clk;
  // One-cycle pulses caught mid-cycle, where they have settled
  always @(negedge clk) begin
    s_wr = s_wr | wr;
    s_skp = s_skp | skp;
    s_pcl = s_pcl | pcl;
    // Busy cycles; an unknown ready counts as busy so it cannot slip by
    if (rdy !== 1'b1) s_busy++;
  end
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) n_mismatch++;
    if (seen !== exp) $display("Error %s expected %h seen %h", nm, exp, seen);
  endtask
  // ****************************************************************
  // One instruction: model, issue, compare
  // ****************************************************************
  task automatic run(input int op, d, a, k, l);
    int i, r;
    bit ew, es;
    r = op == 5 ? (mem[a] + 1) % 256 : (mem[a] + 255) % 256;
    ew = op == 1 || op inside {[3:5]} && d;
    es = op inside {4, 5} && r == 0;
    if (op == 1) mem[a] = 0;
    if (op == 2 || op == 7) w = op == 2 ? 0 : w | k % 256;
    if (op inside {[3:5]} && d) mem[a] = r;
    if (op inside {[3:5]} && !d) w = r;
    if (op inside {1, 2}) z = 1;
    if (op == 3) z = r == 0;
    if (op == 7) z = w == 0;
    {s_wr, s_skp, s_pcl} = 3'b000;
    s_busy = 0;
    // Enable drops with the request: the offer must wait 0 to 3 frozen edges
    @(posedge clk) #1 go = 1;
    ce = 0;
    req = {2'($random(seed)), 3'(op), 1'(d), 7'(a), 11'(k), 7'(l)};
    @(posedge clk) #1 go = 0;
    repeat ($random(seed) & 3) @(posedge clk) #1;
    ce = 1;
    for (i = 0; i < 30 && done !== 1'b1; i++) @(posedge clk) #1;
    if (i == 30) n_mismatch++;
    if (i == 30) end_of_test();
    #50;
    chk("acc", acc, w);
    chk("zero", zero, z);
    chk("write", s_wr, ew);
    if (ew) chk("data", wd, mem[a]);
    if (ew) chk("addr", wa, a);
    chk("skip", s_skp, es);
    chk("load", s_pcl, op == 6);
    chk("busy", s_busy, 1 + (es || op == 6));
    if (op == 6) chk("pc", pc, l / 8 % 16 * 2048 + k);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Reset, seed every register, boundary table, then random traffic
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    for (int a = 0; a < 128; a++) begin
      @(posedge clk) #1 pre_en = 1;
      pre_a = 7'(a);
      pre_d = a == 6 || a == 9 ? 8'hff : a == 5 || a == 7 || a == 8 ? 8'h01 : 8'($random(seed));
      mem[a] = pre_d;
    end
    @(posedge clk) #1 pre_en = 0;
    foreach (tbl[i]) run(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3], tbl[i][4]);
    repeat (80) run($random(seed) & 7, $random(seed) & 1, $random(seed) & 127,
      $random(seed) & 2047, $random(seed) & 127);
    end_of_test();
  end
endmodule // tb
`default_nettype wire

// ### rtl/cdx_exec.v
// Execute stage for clear, decrement, skip-on-zero, jump and OR-literal.
// Assumes the fetch stage drives op and operands on the same clock and
// honours the ready/valid handshake; preload port is for seeding data.
`timescale 1ns/1ns
`default_nettype none
`include "cdx_exec_regs.vh"

module cdx_exec (
  input wire ref_clk_i,                             // Core clock, 10 MHz
  input wire reset_n_i,                             // Async reset, active low
  input wire ce_i,                                  // Clock enable, freezes all
  input wire instr_valid_i,                         // Instruction offered
  input wire [`CDX_OP_W-1:0] op_i,                  // Operation code
  input wire dest_i,                                // Destination select
  input wire [`CDX_ADDR_W-1:0] file_addr_i,         // File register address
  input wire [`CDX_LIT_W-1:0] literal_i,            // Immediate operand
  input wire [`CDX_LATCH_W-1:0] pc_upper_latch_i,   // Upper pc latch value
  input wire preload_en_i,                          // Seed a data register
  input wire [`CDX_ADDR_W-1:0] preload_addr_i,      // Seed address
  input wire [`CDX_DATA_W-1:0] preload_data_i,      // Seed data
  output reg instr_ready_o,                         // Ready for instruction
  output reg done_o,                                // Instruction retired
  output reg [`CDX_DATA_W-1:0] acc_o,               // Accumulator
  output reg zero_o,                                // Zero status flag
  output reg [`CDX_PC_W-1:0] pc_o,                  // Jump target
  output reg pc_load_o,                             // Jump target valid
  output reg skip_o,                                // Discard next fetch
  output reg file_wr_o,                             // Core file write strobe
  output reg [`CDX_ADDR_W-1:0] file_wr_addr_o,      // Core file write address
  output reg [`CDX_DATA_W-1:0] file_wr_data_o       // Core file write data
);

  // ****************************************************************
  // Sequencer state codes
  // ****************************************************************
  localparam [`CDX_ST_W-1:0] ST_IDLE = `CDX_ST_IDLE;
  localparam [`CDX_ST_W-1:0] ST_EXEC = `CDX_ST_EXEC;
  localparam [`CDX_ST_W-1:0] ST_FLUSH = `CDX_ST_FLUSH;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg [`CDX_ST_W-1:0] state_r;
  reg [`CDX_ST_W-1:0] state_nxt;
  reg [`CDX_OP_W-1:0] op_r;
  reg dest_r;
  reg [`CDX_ADDR_W-1:0] addr_r;
  reg [`CDX_LIT_W-1:0] lit_r;
  reg [`CDX_LATCH_W-1:0] latch_r;
  reg [`CDX_DATA_W-1:0] acc_nxt;
  reg zero_nxt;
  reg [`CDX_PC_W-1:0] pc_nxt;
  reg pc_load_nxt;
  reg skip_nxt;
  reg wr_nxt;
  reg [`CDX_DATA_W-1:0] wr_data_nxt;
  reg done_nxt;
  reg [`CDX_DATA_W-1:0] result;
  wire accept;
  wire [`CDX_DATA_W-1:0] file_data;
  wire ram_wr_en;
  wire [`CDX_ADDR_W-1:0] ram_wr_addr;
  wire [`CDX_DATA_W-1:0] ram_wr_data;

  // ****************************************************************
  // Handshake and data register file
  // ****************************************************************
  // Taken only while idle and ready; ready drops for the whole execution
  assign accept = instr_valid_i & instr_ready_o;

  // Core write wins over a preload in the same cycle; preload is dropped
  assign ram_wr_en = wr_nxt | preload_en_i;
  assign ram_wr_addr = wr_nxt ? addr_r : preload_addr_i;
  assign ram_wr_data = wr_nxt ? wr_data_nxt : preload_data_i;

  // Read issued at accept, so the operand is ready in the execute cycle
  cdx_file_ram u_file_ram (
    .ref_clk_i(ref_clk_i),
    .ce_i(ce_i),
    .wr_en_i(ram_wr_en),
    .wr_addr_i(ram_wr_addr),
    .wr_data_i(ram_wr_data),
    .rd_addr_i(file_addr_i),
    .rd_data_o(file_data)
  );

  // ****************************************************************
  // Execute datapath
  // ****************************************************************
  // Defaults hold architectural state; each operation overrides its part
  always @* begin
    state_nxt = state_r;
    acc_nxt = acc_o;
    zero_nxt = zero_o;
    pc_nxt = pc_o;
    pc_load_nxt = 1'b0;
    skip_nxt = 1'b0;
    wr_nxt = 1'b0;
    wr_data_nxt = `CDX_BYTE_ZERO;
    done_nxt = 1'b0;
    result = `CDX_BYTE_ZERO;
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_nxt = ST_IDLE;
        done_nxt = 1'b1;
        case (op_r)
          `CDX_OP_CLEAR_FILE: begin
            wr_nxt = 1'b1;
            wr_data_nxt = `CDX_BYTE_ZERO;
            zero_nxt = 1'b1;
          end
          `CDX_OP_CLEAR_ACC: begin
            acc_nxt = `CDX_BYTE_ZERO;
            zero_nxt = 1'b1;
          end
          `CDX_OP_DECREMENT: begin
            result = file_data - `CDX_BYTE_ONE;
            zero_nxt = (result == `CDX_BYTE_ZERO);
          end
          `CDX_OP_DEC_SKIP: begin
            // Flags deliberately untouched on the skip forms
            result = file_data - `CDX_BYTE_ONE;
            skip_nxt = (result == `CDX_BYTE_ZERO);
          end
          `CDX_OP_INC_SKIP: begin
            result = file_data + `CDX_BYTE_ONE;
            skip_nxt = (result == `CDX_BYTE_ZERO);
          end
          `CDX_OP_JUMP: begin
            pc_nxt = {latch_r[`CDX_LATCH_HI:`CDX_LATCH_LO], lit_r};
            pc_load_nxt = 1'b1;
          end
          `CDX_OP_OR_LIT: begin
            result = acc_o | lit_r[`CDX_BYTE_HI:0];
            acc_nxt = result;
            zero_nxt = (result == `CDX_BYTE_ZERO);
          end
          default: begin
            // No-op and any unused code retire with no effect
            result = `CDX_BYTE_ZERO;
          end
        endcase
        // Register-operand results go where the destination bit says
        if ((op_r == `CDX_OP_DECREMENT) || (op_r == `CDX_OP_DEC_SKIP) ||
            (op_r == `CDX_OP_INC_SKIP)) begin
          if (dest_r == `CDX_DEST_FILE) begin
            wr_nxt = 1'b1;
            wr_data_nxt = result;
          end else begin
            acc_nxt = result;
          end
        end
        // Skips and jumps spend a second cycle flushing the next fetch
        if (skip_nxt || pc_load_nxt) begin
          state_nxt = ST_FLUSH;
          done_nxt = 1'b0;
        end
      end
      ST_FLUSH: begin
        // Stands in for the discarded instruction as a no-op
        state_nxt = ST_IDLE;
        done_nxt = 1'b1;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Operand capture
  // ****************************************************************
  // Operands held so the fetch stage may move on after the handshake
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op_r <= `CDX_OP_NOP;
      dest_r <= `CDX_DEST_ACC;
      addr_r <= `CDX_ADDR_ZERO;
      lit_r <= `CDX_LIT_ZERO;
      latch_r <= {`CDX_LATCH_W{1'b0}};
    end else if (ce_i && accept) begin
      op_r <= op_i;
      dest_r <= dest_i;
      addr_r <= file_addr_i;
      lit_r <= literal_i;
      latch_r <= pc_upper_latch_i;
    end
  end

  // ****************************************************************
  // State and output registers
  // ****************************************************************
  // Every output is a flop so the fetch stage sees clean timing
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= ST_IDLE;
      instr_ready_o <= 1'b0;
      done_o <= 1'b0;
      acc_o <= `CDX_BYTE_ZERO;
      zero_o <= 1'b0;
      pc_o <= `CDX_PC_ZERO;
      pc_load_o <= 1'b0;
      skip_o <= 1'b0;
      file_wr_o <= 1'b0;
      file_wr_addr_o <= `CDX_ADDR_ZERO;
      file_wr_data_o <= `CDX_BYTE_ZERO;
    end else if (ce_i) begin
      state_r <= state_nxt;
      // Ready comes up one edge after reset release and on the same edge as each retire
      instr_ready_o <= (state_nxt == ST_IDLE);
      done_o <= done_nxt;
      acc_o <= acc_nxt;
      zero_o <= zero_nxt;
      pc_o <= pc_nxt;
      pc_load_o <= pc_load_nxt;
      skip_o <= skip_nxt;
      file_wr_o <= wr_nxt;
      if (wr_nxt) begin
        file_wr_addr_o <= addr_r;
        file_wr_data_o <= wr_data_nxt;
      end
    end
  end

endmodule // cdx_exec
`default_nettype wire

// ### rtl/cdx_exec_regs.vh
// Constants for the instruction execute block: operation codes, field
// widths, fixed values and state codes.
// Assumes it is included by bare name from the design files only.
`ifndef CDX_EXEC_REGS_VH
`define CDX_EXEC_REGS_VH

// ****************************************************************
// Operation codes presented by the fetch stage
// ****************************************************************
`define CDX_OP_W 3
`define CDX_OP_NOP 3'h0
`define CDX_OP_CLEAR_FILE 3'h1
`define CDX_OP_CLEAR_ACC 3'h2
`define CDX_OP_DECREMENT 3'h3
`define CDX_OP_DEC_SKIP 3'h4
`define CDX_OP_INC_SKIP 3'h5
`define CDX_OP_JUMP 3'h6
`define CDX_OP_OR_LIT 3'h7

// ****************************************************************
// Field widths and positions
// ****************************************************************
`define CDX_DATA_W 8
`define CDX_ADDR_W 7
`define CDX_DEPTH 128
`define CDX_LIT_W 11
`define CDX_PC_W 15
`define CDX_LATCH_W 7
`define CDX_LATCH_HI 6
`define CDX_LATCH_LO 3
`define CDX_BYTE_HI 7

// ****************************************************************
// Fixed values
// ****************************************************************
`define CDX_BYTE_ZERO 8'h00
`define CDX_BYTE_ONE 8'h01
`define CDX_ADDR_ZERO 7'h00
`define CDX_LIT_ZERO 11'h000
`define CDX_PC_ZERO 15'h0000
`define CDX_DEST_ACC 1'h0
`define CDX_DEST_FILE 1'h1

// ****************************************************************
// Sequencer state codes
// ****************************************************************
`define CDX_ST_W 2
`define CDX_ST_IDLE 2'h0
`define CDX_ST_EXEC 2'h1
`define CDX_ST_FLUSH 2'h2

`endif

// ### rtl/cdx_file_ram.v
// Data register file: 128 bytes, one write port, one read port.
// Assumes one clock; read data come out of a register one edge later.
`timescale 1ns/1ns
`default_nettype none
`include "cdx_exec_regs.vh"

module cdx_file_ram (
  input wire ref_clk_i,                          // Core clock
  input wire ce_i,                               // Clock enable, freezes all
  input wire wr_en_i,                            // Write strobe
  input wire [`CDX_ADDR_W-1:0] wr_addr_i,        // Write address
  input wire [`CDX_DATA_W-1:0] wr_data_i,        // Write data
  input wire [`CDX_ADDR_W-1:0] rd_addr_i,        // Read address
  output reg [`CDX_DATA_W-1:0] rd_data_o         // Registered read data
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  // No reset on the array; contents are undefined until written
  reg [`CDX_DATA_W-1:0] mem_r [0:`CDX_DEPTH-1];

  // Write port and registered read, read-before-write on a collision
  always @(posedge ref_clk_i) begin
    if (ce_i) begin
      if (wr_en_i) begin
        mem_r[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem_r[rd_addr_i];
    end
  end

endmodule // cdx_file_ram
`default_nettype wire
